// ===== logic/hpp_pkg.sv
`default_nettype none
package hpp_pkg;
  // Stretched internal reset, oscillator settling and propagation.
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned RST_STRETCH_NS = 1000;
  localparam int unsigned RST_STRETCH_CYC = (RST_STRETCH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] ACK_PULSE_CYC = 2'h2;
  // Host-reachable word window of the dual-access RAM.
  localparam logic [15:0] MMR_WORDS = 16'h0060;
  localparam logic [16:0] DUAL_RAM_WORDS = 17'h08000;
  // Host access select codes.
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_DATA_FIX = 2'h3;
  // Host view of the port control register.
  localparam int unsigned PCR_H2C = 1;
  localparam int unsigned PCR_PROCESSOR_TO_HOST_INTERRUPT_BIT = 2;
  localparam int unsigned PCR_MUX = 3;
  // Processor register offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_IEN = 4'h2;
  localparam logic [3:0] REG_ICLR = 4'h3;
  localparam logic [3:0] REG_ADDR = 4'h4;
  // Control register bits.
  localparam int unsigned CTL_PROCESSOR_TO_HOST_INTERRUPT_BIT = 0;
  localparam int unsigned CTL_H2C = 1;
  localparam int unsigned CTL_MUX = 2;
  localparam int unsigned CTL_DONE = 3;
  // Status event bits.
  localparam int unsigned EV_WR = 0;
  localparam int unsigned EV_RD = 1;
  localparam int unsigned EV_H2C = 2;
  localparam int unsigned EV_RANGE = 3;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_RDATA, S_HOLD} hpp_state_t;

  typedef struct packed {
    logic en;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hpp_mem_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } hpp_reg_req_t;
endpackage
`default_nettype wire

// ===== logic/hpp_host_port.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hpp_host_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mode_strap_pin_i,
  input wire logic boot_mode_i,
  input wire logic port_idle_i,
  input wire logic cpu_idle_i,
  input wire logic port_enable_pin_i,
  input wire logic host_chip_select_n_i,
  input wire logic host_data_strobe_first_n_i,
  input wire logic host_data_strobe_second_n_i,
  input wire logic host_read_i,
  input wire logic [1:0] host_access_select_i,
  input wire logic host_control_pin_zero_i,
  input wire logic host_control_pin_one_i,
  input wire logic [15:0] host_address_bus_i,
  input wire logic [15:0] host_data_bus_i,
  output logic [15:0] host_data_bus_o,
  output logic [15:0] host_data_oe_o,
  output logic host_ready_o,
  output logic host_interrupt_n_o,
  output logic interrupt_acknowledge_pin_n_o,
  output logic boot_ready_pin_o,
  output logic cpu_reset_o,
  output logic ext_mem_enable_o,
  output hpp_pkg::hpp_mem_req_t mem_req_o,
  input wire logic [15:0] mem_rdata_i,
  input wire hpp_pkg::hpp_reg_req_t reg_req_i,
  output logic [15:0] reg_rdata_o,
  output logic irq_o
);
  typedef struct packed {
    hpp_pkg::hpp_state_t st;
    logic [15:0] cnt;
    logic [1:0] ack_cnt;
    logic done;
    logic mux;
    logic act_q;
    logic [15:0] addr;
    logic [15:0] wbuf;
    logic [15:0] dout;
    logic [1:0] sel;
    logic rd;
    logic bil;
    logic [1:0] lat_sel;
    logic lat_bil;
    logic has_seen;
    logic processor_to_host_interrupt_bit;
    logic h2c;
    logic [3:0] stat;
    logic [3:0] ien;
    logic [15:0] rdata;
    hpp_pkg::hpp_mem_req_t mem;
  } hpp_regs_t;

  hpp_regs_t cur_r;
  hpp_regs_t cur_nxt;
  logic act;
  logic [1:0] esel;
  logic ebil;
  logic final_w;
  logic [15:0] wword;
  logic [15:0] taddr;
  logic in_range;
  logic [15:0] pcr;
  logic [3:0] ev;
  logic [3:0] irq_mask;

  // Host strobe; strobes before release or while idle are ignored.
  // Reset gating.
  assign act = port_enable_pin_i & ~host_chip_select_n_i & cur_r.done & ~port_idle_i
    & (~host_data_strobe_first_n_i | ~host_data_strobe_second_n_i);

  // Address strobe latch selects the access type in multiplexed mode.
  // Latched control.
  assign esel = (cur_r.mux & cur_r.has_seen) ? cur_r.lat_sel : host_access_select_i;
  assign ebil = (cur_r.mux & cur_r.has_seen) ? cur_r.lat_bil : host_control_pin_one_i;

  // A word completes on the second byte in multiplexed mode.
  assign final_w = ~cur_r.mux | cur_r.bil;
  assign wword = cur_r.mux ? {host_data_bus_i[7:0], cur_r.wbuf[7:0]} : host_data_bus_i;

  // Non-multiplexed data accesses use the address on the host bus.
  // Full address.
  assign taddr = cur_r.mux ? cur_r.addr : host_address_bus_i;
  assign in_range = (taddr >= hpp_pkg::MMR_WORDS) && ({1'b0, taddr} < hpp_pkg::DUAL_RAM_WORDS);

  // Host view of the port control register.
  always_comb begin
    pcr = 16'h0000;
    pcr[hpp_pkg::PCR_H2C] = cur_r.h2c;
    pcr[hpp_pkg::PCR_PROCESSOR_TO_HOST_INTERRUPT_BIT] = cur_r.processor_to_host_interrupt_bit;
    pcr[hpp_pkg::PCR_MUX] = cur_r.mux;
  end

  // Next-state logic for the whole block.
  always_comb begin
    cur_nxt = cur_r;
    ev = 4'h0;
    cur_nxt.mem.en = 1'b0;
    cur_nxt.mem.we = 1'b0;
    cur_nxt.act_q = act;
    // Stretch the pin reset and sample the strap meanwhile.
    // Reset stretch.
    if (!cur_r.done) begin
      cur_nxt.mux = mode_strap_pin_i;
      cur_nxt.cnt = cur_r.cnt + 16'h0001;
      if (cur_r.cnt == 16'(hpp_pkg::RST_STRETCH_CYC - 1)) begin
        cur_nxt.done = 1'b1;
        cur_nxt.ack_cnt = hpp_pkg::ACK_PULSE_CYC;
      end
    end
    if (cur_r.ack_cnt != 2'h0) begin
      cur_nxt.ack_cnt = cur_r.ack_cnt - 2'h1;
    end
    // Address strobe captures select and byte id while low.
    if (cur_r.mux && !host_control_pin_zero_i) begin
      cur_nxt.lat_sel = host_access_select_i;
      cur_nxt.lat_bil = host_control_pin_one_i;
      cur_nxt.has_seen = 1'b1;
    end
    // Host transfer sequence.
    case (cur_r.st)
      hpp_pkg::S_IDLE: begin
        if (act && !cur_r.act_q) begin
          cur_nxt.sel = esel;
          cur_nxt.bil = cur_r.mux ? ebil : 1'b1;
          cur_nxt.rd = host_read_i;
          cur_nxt.st = hpp_pkg::S_ISSUE;
        end
      end
      hpp_pkg::S_ISSUE: begin
        cur_nxt.st = hpp_pkg::S_HOLD;
        if (!cur_r.rd && !final_w) begin
          cur_nxt.wbuf[7:0] = host_data_bus_i[7:0];
        end
        case (cur_r.sel)
          hpp_pkg::SEL_CTRL: begin
            if (cur_r.rd) begin
              cur_nxt.dout = cur_r.mux ? {8'h00, cur_r.bil ? pcr[15:8] : pcr[7:0]} : pcr;
            end else if (final_w) begin
              // Host writes one to raise the CPU interrupt, one to clear its own.
              if (wword[hpp_pkg::PCR_H2C]) begin
                cur_nxt.h2c = 1'b1;
                ev[hpp_pkg::EV_H2C] = 1'b1;
              end
              if (wword[hpp_pkg::PCR_PROCESSOR_TO_HOST_INTERRUPT_BIT]) begin
                cur_nxt.processor_to_host_interrupt_bit = 1'b0;
              end
            end
          end
          hpp_pkg::SEL_ADDR: begin
            if (cur_r.rd) begin
              cur_nxt.dout = cur_r.mux ? {8'h00, cur_r.bil ? cur_r.addr[15:8] : cur_r.addr[7:0]}
                : cur_r.addr;
            end else if (final_w) begin
              cur_nxt.addr = wword;
            end
          end
          default: begin
            cur_nxt.mem.addr = taddr;
            cur_nxt.addr = taddr;
            if (cur_r.rd && cur_r.mux && cur_r.bil) begin
              cur_nxt.dout = {8'h00, cur_r.wbuf[15:8]};
            end else if (!in_range) begin
              cur_nxt.dout = 16'h0000;
              cur_nxt.wbuf = 16'h0000;
              ev[hpp_pkg::EV_RANGE] = cur_r.rd | final_w;
            end else if (cur_r.rd) begin
              cur_nxt.mem.en = cur_r.done;
              cur_nxt.st = hpp_pkg::S_RDATA;
            end else if (final_w) begin
              cur_nxt.mem.en = cur_r.done;
              cur_nxt.mem.we = 1'b1;
              cur_nxt.mem.wdata = wword;
            end
          end
        endcase
      end
      hpp_pkg::S_RDATA: begin
        cur_nxt.wbuf = mem_rdata_i;
        cur_nxt.dout = cur_r.mux ? {8'h00, mem_rdata_i[7:0]} : mem_rdata_i;
        cur_nxt.st = hpp_pkg::S_HOLD;
      end
      hpp_pkg::S_HOLD: begin
        if (!act) begin
          cur_nxt.st = hpp_pkg::S_IDLE;
          cur_nxt.has_seen = 1'b0;
          if (final_w && (cur_r.sel == hpp_pkg::SEL_DATA_INC
              || cur_r.sel == hpp_pkg::SEL_DATA_FIX)) begin
            ev[hpp_pkg::EV_RD] = cur_r.rd;
            ev[hpp_pkg::EV_WR] = ~cur_r.rd;
          end
          if (final_w && cur_r.sel == hpp_pkg::SEL_DATA_INC) begin
            cur_nxt.addr = cur_r.addr + 16'h0001;
          end
        end
      end
      default: begin
        cur_nxt.st = hpp_pkg::S_IDLE;
      end
    endcase
    // Processor register writes.
    if (reg_req_i.we) begin
      case (reg_req_i.addr)
        hpp_pkg::REG_CTRL: begin
          if (reg_req_i.wdata[hpp_pkg::CTL_PROCESSOR_TO_HOST_INTERRUPT_BIT]) begin
            cur_nxt.processor_to_host_interrupt_bit = 1'b1;
          end
          // A host request raised in the same cycle wins over this clear.
          if (reg_req_i.wdata[hpp_pkg::CTL_H2C] && !ev[hpp_pkg::EV_H2C]) begin
            cur_nxt.h2c = 1'b0;
          end
        end
        hpp_pkg::REG_IEN: begin
          cur_nxt.ien = reg_req_i.wdata[3:0];
        end
        default: begin
          cur_nxt.ien = cur_r.ien;
        end
      endcase
    end
    // Sticky status; a new event wins over a clear.
    if (reg_req_i.we && reg_req_i.addr == hpp_pkg::REG_ICLR) begin
      cur_nxt.stat = (cur_r.stat & ~reg_req_i.wdata[3:0]) | ev;
    end else begin
      cur_nxt.stat = cur_r.stat | ev;
    end
    // Processor register reads, answered in the next cycle.
    cur_nxt.rdata = 16'h0000;
    if (reg_req_i.re) begin
      case (reg_req_i.addr)
        hpp_pkg::REG_CTRL: begin
          cur_nxt.rdata[hpp_pkg::CTL_PROCESSOR_TO_HOST_INTERRUPT_BIT] = cur_r.processor_to_host_interrupt_bit;
          cur_nxt.rdata[hpp_pkg::CTL_H2C] = cur_r.h2c;
          cur_nxt.rdata[hpp_pkg::CTL_MUX] = cur_r.mux;
          cur_nxt.rdata[hpp_pkg::CTL_DONE] = cur_r.done;
        end
        hpp_pkg::REG_STAT: cur_nxt.rdata = {12'h000, cur_r.stat};
        hpp_pkg::REG_IEN: cur_nxt.rdata = {12'h000, cur_r.ien};
        hpp_pkg::REG_ADDR: cur_nxt.rdata = cur_r.addr;
        default: cur_nxt.rdata = 16'h0000;
      endcase
    end
    if (rst_i) begin
      cur_nxt = '0;
      cur_nxt.ien = hpp_pkg::IRQ_EN_RST;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    cur_r <= cur_nxt;
  end

  // Host-to-processor request cannot reach the CPU while it idles.
  // No wake.
  always_comb begin
    irq_mask = cur_r.ien;
    irq_mask[hpp_pkg::EV_H2C] = cur_r.ien[hpp_pkg::EV_H2C] & ~cpu_idle_i;
  end
  assign irq_o = |(cur_r.stat & irq_mask);

  // Host pins and system outputs.
  // Ready low while an access is in flight.
  assign host_ready_o = cur_r.done & (cur_r.st == hpp_pkg::S_IDLE || cur_r.st == hpp_pkg::S_HOLD);
  assign host_data_bus_o = cur_r.dout;
  assign host_data_oe_o = (act && cur_r.rd && cur_r.st == hpp_pkg::S_HOLD)
    ? (cur_r.mux ? 16'h00FF : 16'hFFFF) : 16'h0000;
  assign host_interrupt_n_o = ~cur_r.processor_to_host_interrupt_bit;
  assign interrupt_acknowledge_pin_n_o = (cur_r.ack_cnt == 2'h0);
  assign boot_ready_pin_o = boot_mode_i & cur_r.done;
  assign cpu_reset_o = ~cur_r.done;
  // External memory off in 16-bit mode.
  assign ext_mem_enable_o = cur_r.done & cur_r.mux;
  assign mem_req_o = cur_r.mem;
  assign reg_rdata_o = cur_r.rdata;
endmodule // hpp_host_port
`default_nettype wire

// ===== sim/hpp_props.sv
`timescale 1ns/1ps
`default_nettype none
module hpp_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mode_strap_pin_i,
  input wire logic port_idle_i,
  input wire logic port_enable_pin_i,
  input wire logic host_chip_select_n_i,
  input wire logic host_data_strobe_first_n_i,
  input wire logic host_data_strobe_second_n_i,
  input wire logic host_read_i,
  input wire logic [1:0] host_access_select_i,
  input wire logic [15:0] host_address_bus_i,
  input wire logic [15:0] host_data_bus_i,
  input wire logic [15:0] host_data_oe_o,
  input wire logic host_ready_o,
  input wire logic host_interrupt_n_o,
  input wire logic interrupt_acknowledge_pin_n_o,
  input wire logic cpu_reset_o,
  input wire logic ext_mem_enable_o,
  input wire hpp_pkg::hpp_mem_req_t mem_req_o,
  input wire hpp_pkg::hpp_reg_req_t reg_req_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic stb;
  logic stb_r;
  logic take;
  logic wr;
  // Strobe decode, first active cycle and an in-range 16-bit data write.
  assign stb = port_enable_pin_i & ~host_chip_select_n_i &
               ~(host_data_strobe_first_n_i & host_data_strobe_second_n_i);
  assign take = stb & ~stb_r & host_ready_o & ~port_idle_i;
  assign wr = take & ~host_read_i & ~mode_strap_pin_i & host_access_select_i[0] &
              (host_address_bus_i >= hpp_pkg::MMR_WORDS) & ~host_address_bus_i[15];
  // Previous strobe level.
  always_ff @(posedge clk_i) begin
    stb_r <= rst_i ? 1'b0 : stb;
  end
  a_no_mem_reset: assert property (cpu_reset_o |-> !mem_req_o.en)
    else $error("memory request during reset");
  a_mem_in_range: assert property (mem_req_o.en |-> mem_req_o.addr >= hpp_pkg::MMR_WORDS
    && {1'b0, mem_req_o.addr} < hpp_pkg::DUAL_RAM_WORDS)
    else $error("memory address out of range");
  a_ack_two_cycles: assert property ($fell(interrupt_acknowledge_pin_n_o) |=>
    !interrupt_acknowledge_pin_n_o ##1 interrupt_acknowledge_pin_n_o) else $error("ack width");
  a_ready_in_reset: assert property (cpu_reset_o |-> !host_ready_o)
    else $error("ready during reset");
  a_ext_mem_off: assert property (!mode_strap_pin_i |-> !ext_mem_enable_o)
    else $error("external memory enabled in 16-bit mode");
  a_oe_width: assert property (host_data_oe_o != 16'h0000 |->
    host_data_oe_o == (mode_strap_pin_i ? 16'h00FF : 16'hFFFF)) else $error("data enable width");
  a_write_issue: assert property (wr |-> ##2 mem_req_o.en && mem_req_o.we &&
    mem_req_o.addr == $past(host_address_bus_i, 2)
    && mem_req_o.wdata == $past(host_data_bus_i, 2))
    else $error("write not issued");
  a_ready_drop: assert property (take |=> !host_ready_o)
    else $error("ready stayed high");
  a_processor_to_host_interrupt_bit_raise: assert property (reg_req_i.we && reg_req_i.addr == hpp_pkg::REG_CTRL &&
    reg_req_i.wdata[hpp_pkg::CTL_PROCESSOR_TO_HOST_INTERRUPT_BIT] |-> ##[1:2] !host_interrupt_n_o) else $error("no host irq");
endmodule // hpp_props
bind hpp_host_port hpp_props u_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .mode_strap_pin_i(mode_strap_pin_i),
  .port_idle_i(port_idle_i),
  .port_enable_pin_i(port_enable_pin_i),
  .host_chip_select_n_i(host_chip_select_n_i),
  .host_data_strobe_first_n_i(host_data_strobe_first_n_i),
  .host_data_strobe_second_n_i(host_data_strobe_second_n_i),
  .host_read_i(host_read_i),
  .host_access_select_i(host_access_select_i),
  .host_address_bus_i(host_address_bus_i),
  .host_data_bus_i(host_data_bus_i),
  .host_data_oe_o(host_data_oe_o),
  .host_ready_o(host_ready_o),
  .host_interrupt_n_o(host_interrupt_n_o),
  .interrupt_acknowledge_pin_n_o(interrupt_acknowledge_pin_n_o),
  .cpu_reset_o(cpu_reset_o),
  .ext_mem_enable_o(ext_mem_enable_o),
  .mem_req_o(mem_req_o),
  .reg_req_i(reg_req_i)
);
`default_nettype wire

// ===== sim/hpp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [15:0] data_i,
  output logic cs_n_o,
  output logic ds1_n_o,
  output logic rd_o,
  output logic [1:0] sel_o,
  output logic bil_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o,
  output int late_o
);
  initial begin
    cs_n_o = 1'b1;
    ds1_n_o = 1'b1;
    rd_o = 1'b0;
    sel_o = 2'h0;
    bil_o = 1'b0;
    addr_o = 16'h0000;
    data_o = 16'h0000;
    late_o = 0;
  end
  // One host transfer, held until ready is sampled high.
  task automatic xfer(input logic rd, input logic [1:0] sel, input logic bil,
                      input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    ds1_n_o <= 1'b0;
    rd_o <= rd;
    sel_o <= sel;
    bil_o <= bil;
    addr_o <= a;
    data_o <= d;
    @(posedge clk_i);
    n = 0;
    // Wait for ready; a transfer that never sees it is counted late.
    do begin
      @(posedge clk_i);
      n++;
    end while (ready_i !== 1'b1 && n < 20);
    if (ready_i !== 1'b1) late_o++;
    q = data_i;
    cs_n_o <= 1'b1;
    ds1_n_o <= 1'b1;
    data_o <= ~data_o; // Released bus shows the inverse.
  endtask
endmodule // hpp_host_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap = 1'b0;
  logic idle = 1'b0;
  logic as_n = 1'b1;
  logic cs_n, ds1_n, rd, bil, ready, processor_to_host_interrupt_bit_n, ack_n, boot_rdy, cpu_rst, ext_en, irq;
  logic [1:0] sel;
  logic [15:0] haddr, hdo, ddo, doe, mrd, rdat, q;
  logic [15:0] mem [0:32767];
  wire logic [15:0] hbus;
  int late;
  hpp_pkg::hpp_mem_req_t mq;
  hpp_pkg::hpp_reg_req_t rq = '0;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  // Clock at 25 ns.
  initial forever #12.5 clk_i = ~clk_i;
  // Data wire resolved from both drivers.
  assign hbus = (doe & ddo) | (~doe & hdo);
  hpp_host_model h (.clk_i(clk_i), .ready_i(ready), .data_i(hbus), .cs_n_o(cs_n), .ds1_n_o(ds1_n),
    .rd_o(rd), .sel_o(sel), .bil_o(bil), .addr_o(haddr), .data_o(hdo), .late_o(late));
  hpp_host_port DUT (.clk_i(clk_i), .rst_i(rst_i), .mode_strap_pin_i(strap), .boot_mode_i(1'b1),
    .port_idle_i(1'b0), .cpu_idle_i(idle), .port_enable_pin_i(1'b1), .host_chip_select_n_i(cs_n),
    .host_data_strobe_first_n_i(ds1_n), .host_data_strobe_second_n_i(1'b1), .host_read_i(rd),
    .host_access_select_i(sel), .host_control_pin_zero_i(as_n), .host_control_pin_one_i(bil),
    .host_address_bus_i(haddr), .host_data_bus_i(hbus), .host_data_bus_o(ddo),
    .host_data_oe_o(doe), .host_ready_o(ready), .host_interrupt_n_o(processor_to_host_interrupt_bit_n),
    .interrupt_acknowledge_pin_n_o(ack_n),
    .boot_ready_pin_o(boot_rdy), .cpu_reset_o(cpu_rst), .ext_mem_enable_o(ext_en), .mem_req_o(mq),
    .mem_rdata_i(mrd), .reg_req_i(rq), .reg_rdata_o(rdat), .irq_o(irq));
  // Memory read data stands in the request cycle, where the port samples it.
  assign mrd = mem[mq.addr[14:0]];
  // Memory writes at the clock edge; the watchdog cuts a hang short.
  always @(posedge clk_i) begin
    cyc++;
    if (mq.en && mq.we) mem[mq.addr[14:0]] <= mq.wdata;
    if (cyc == 5000) begin
      errors++;
      results;
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    rq <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    rq <= '0;
    @(posedge clk_i);
  endtask
  task rr(input logic [3:0] a);
    @(posedge clk_i);
    rq <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    rq <= '0;
    @(posedge clk_i);
    q = rdat;
  endtask
  task rst_seq(input logic s);
    rst_i <= 1'b1;
    strap <= s;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    n = 0;
    while (cpu_rst !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    repeat (4) @(posedge clk_i);
  endtask
  task results;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence.
  initial begin
    rst_seq(1'b0);
    chk(16'(n >= hpp_pkg::RST_STRETCH_CYC && n <= hpp_pkg::RST_STRETCH_CYC + 2), 16'h0001);
    chk(ext_en, 1'b0);
    chk(boot_rdy, 1'b1);
    $display("test reset done");
    h.xfer(1'b0, hpp_pkg::SEL_DATA_FIX, 1'b0, 16'h0100, 16'hA5C3, q);
    h.xfer(1'b1, hpp_pkg::SEL_DATA_FIX, 1'b0, 16'h0100, 16'h0000, q);
    chk(q, 16'hA5C3);
    h.xfer(1'b0, hpp_pkg::SEL_DATA_INC, 1'b0, 16'h0200, 16'h1111, q);
    h.xfer(1'b0, hpp_pkg::SEL_DATA_INC, 1'b0, 16'h0201, 16'h2222, q);
    rr(hpp_pkg::REG_ADDR);
    chk(q, 16'h0202);
    h.xfer(1'b1, hpp_pkg::SEL_DATA_FIX, 1'b0, 16'h0201, 16'h0000, q);
    chk(q, 16'h2222);
    $display("test data16 done");
    rw(hpp_pkg::REG_ICLR, 16'h000F);
    rw(hpp_pkg::REG_IEN, 16'h000F);
    for (int i = 0; i < 2; i++) begin
      h.xfer(1'b1, hpp_pkg::SEL_DATA_FIX, 1'b0, i ? 16'h8000 : 16'h005F, 16'h0000, q);
      chk(q, 16'h0000);
      rr(hpp_pkg::REG_STAT);
      chk(q[hpp_pkg::EV_RANGE], 1'b1);
      chk(irq, 1'b1);
      rw(hpp_pkg::REG_ICLR, 16'h000F);
      chk(irq, 1'b0);
    end
    $display("test range done");
    rw(hpp_pkg::REG_CTRL, 16'h0001);
    chk(processor_to_host_interrupt_bit_n, 1'b0);
    h.xfer(1'b0, hpp_pkg::SEL_CTRL, 1'b0, 16'h0000, 16'h0001 << hpp_pkg::PCR_PROCESSOR_TO_HOST_INTERRUPT_BIT, q);
    @(posedge clk_i);
    chk(processor_to_host_interrupt_bit_n, 1'b1);
    idle <= 1'b1;
    h.xfer(1'b0, hpp_pkg::SEL_CTRL, 1'b0, 16'h0000, 16'h0001 << hpp_pkg::PCR_H2C, q);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    idle <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    $display("test irq done");
    rst_seq(1'b1);
    chk(ext_en, 1'b1);
    h.xfer(1'b0, hpp_pkg::SEL_ADDR, 1'b0, 16'h0000, 16'h0000, q);
    h.xfer(1'b0, hpp_pkg::SEL_ADDR, 1'b1, 16'h0000, 16'h0003, q);
    h.xfer(1'b0, hpp_pkg::SEL_DATA_FIX, 1'b0, 16'h0000, 16'h0034, q);
    h.xfer(1'b0, hpp_pkg::SEL_DATA_FIX, 1'b1, 16'h0000, 16'h0012, q);
    @(posedge clk_i);
    chk(mem[15'h0300], 16'h1234);
    h.xfer(1'b1, hpp_pkg::SEL_DATA_FIX, 1'b0, 16'h0000, 16'h0000, q);
    chk(q[7:0], 8'h34);
    h.xfer(1'b1, hpp_pkg::SEL_DATA_FIX, 1'b1, 16'h0000, 16'h0000, q);
    chk(q[7:0], 8'h12);
    // An address strobe pulse latches the still-driven high-byte data select.
    @(posedge clk_i);
    as_n <= 1'b0;
    @(posedge clk_i);
    as_n <= 1'b1;
    h.xfer(1'b1, hpp_pkg::SEL_ADDR, 1'b0, 16'h0000, 16'h0000, q);
    chk(q[7:0], 8'h12);
    $display("test mux done");
    chk(16'(late), 16'h0000);
    results;
  end
endmodule // tb
`default_nettype wire
